// File: hw/radio_cfg_defines.svh
// Register indices, field positions, reset values and masks
`ifndef RADIO_CFG_DEFINES_SVH
`define RADIO_CFG_DEFINES_SVH
`define IDX_LEN_LIMIT   16'hdf02
`define IDX_FILT_CTRL   16'hdf03
`define IDX_CTRL_B      16'hdf04
`define IDX_DEV_ADDR    16'hdf05
`define IDX_CHANNEL_INDEX        16'hdf06
`define IDX_IF_CTRL     16'hdf07
`define IDX_OFS_CTRL    16'hdf08
`define IDX_BASE_WORD_A_HI     16'hdf09
`define IDX_BASE_WORD_A_MID    16'hdf0a
`define IDX_BASE_WORD_A_LO     16'hdf0b
`define IDX_SPACING     16'hdf40
`define BIT_WHITEN      6
`define BIT_FMT_HI      5
`define BIT_FMT_LO      4
`define BIT_LEGACY      3
`define BIT_CRC         2
`define BIT_LEN_HI      1
`define BIT_LEN_LO      0
`define RST_CTRL_B      8'h45
`define RST_DEV_ADDR    8'h00
`define RST_CHANNEL_INDEX        8'h00
`define RST_IF_CTRL     8'h0f
`define RST_OFS_CTRL    8'h00
`define RST_BASE_WORD_A_HI     6'h1e
`define RST_BASE_WORD_A_MID    8'hc4
`define RST_BASE_WORD_A_LO     8'hec
`define RST_LEN_LIMIT   8'hff
`define RST_FILT_CTRL   2'h0
`define RST_SPACING     8'h00
`define MASK_CTRL_B     8'h7f
`define MASK_IF_CTRL    8'h3f
`define BASE_WORD_A_TOP        2'h1
`define OFS_SHIFT       2
`define IF_SHIFT        6
`define PN9_SEED        9'h1ff
`endif

// File: hw/radio_cfg_pkg.sv
// Types for the packet and synthesizer configuration block
package radio_cfg_pkg;
   typedef enum logic [1:0] {
      LEN_FIXED = 2'h0, LEN_VAR = 2'h1, LEN_RSV2 = 2'h2, LEN_RSV3 = 2'h3
   } len_cfg_e;
   typedef enum logic [1:0] {
      FMT_NORMAL = 2'h0, FMT_RSV1 = 2'h1, FMT_PN9 = 2'h2, FMT_RSV3 = 2'h3
   } pkt_fmt_e;
   typedef enum logic [1:0] {
      ACHK_NONE = 2'h0, ACHK_PLAIN = 2'h1, ACHK_BC0 = 2'h2, ACHK_BC0FF = 2'h3
   } addr_chk_e;
   typedef struct packed {
      logic       whiten_on;
      logic       legacy_crc;
      logic       crc_tx_append;
      logic       crc_rx_check;
      logic       tx_pn9;
      logic       fmt_reserved;
      logic       fixed_len;
      logic       var_len;
      logic       len_reserved;
      logic [7:0] len_limit;
   } pkt_cfg_s;
   typedef struct packed {
      logic [23:0] synth_word;
      logic [4:0]  mixer_if;
   } synth_cfg_s;
endpackage

// File: hw/radio_packet_base_word_a_config.sv
// APB register block for packet engine and synthesizer settings
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`include "radio_cfg_defines.svh"
module radio_packet_base_word_a_config
   import radio_cfg_pkg::*;
#(
   parameter int AW = 18
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [AW-1:0] paddr,
   input  wire logic [31:0]   pwdata,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic          rx_mode,
   input  wire logic          tx_bit_strobe,
   input  wire logic          rx_addr_strobe,
   input  wire logic [7:0]    rx_addr_byte,
   output pkt_cfg_s           pkt_cfg,
   output synth_cfg_s         synth_cfg,
   output logic               pn9_bit,
   output logic               addr_accept,
   output logic               addr_valid
);

   logic [7:0]  ctrl_b_r;
   logic [7:0]  dev_addr_r;
   logic [7:0]  channel_index_r;
   logic [7:0]  if_ctrl_r;
   logic [7:0]  ofs_r;
   logic [5:0]  base_word_a_hi_r;
   logic [7:0]  base_word_a_mid_r;
   logic [7:0]  base_word_a_lo_r;
   logic [7:0]  len_limit_r;
   logic [1:0]  filt_ctrl_r;
   logic [7:0]  spacing_r;
   logic [31:0] prdata_r;
   logic        pready_r;
   logic        pslverr_r;
   pkt_cfg_s    pkt_cfg_r;
   synth_cfg_s  synth_r;
   logic [8:0]  lfsr_r;
   logic        pn9_r;
   logic        accept_r;
   logic        valid_r;
   logic [15:0] idx;
   logic        hit;
   logic        wr_en;
   logic [7:0]  wd;
   logic [7:0]  rd_nxt;
   logic [23:0] base_w;
   logic [23:0] tune_w;
   logic [23:0] synth_nxt;
   logic [15:0] channel_index_prod;

   function automatic logic reg_hit(input logic [15:0] i);
      case (i)
         `IDX_LEN_LIMIT, `IDX_FILT_CTRL, `IDX_CTRL_B, `IDX_DEV_ADDR,
         `IDX_CHANNEL_INDEX, `IDX_IF_CTRL, `IDX_OFS_CTRL, `IDX_BASE_WORD_A_HI,
         `IDX_BASE_WORD_A_MID, `IDX_BASE_WORD_A_LO, `IDX_SPACING: reg_hit = 1'b1;
         default: reg_hit = 1'b0;
      endcase
   endfunction

   function automatic logic addr_match(input logic [1:0] mode,
                                       input logic [7:0] dev,
                                       input logic [7:0] b);
      case (mode)
         ACHK_NONE:  addr_match = 1'b1;
         ACHK_PLAIN: addr_match = (b == dev);
         ACHK_BC0:   addr_match = (b == dev) || (b == 8'h00);
         ACHK_BC0FF: addr_match = (b == dev) || (b == 8'h00) || (b == 8'hff);
         default:    addr_match = 1'b0;
      endcase
   endfunction

   assign idx   = paddr[17:2];
   assign hit   = reg_hit(idx);
   assign wd    = pwdata[7:0];
   assign wr_en = psel && penable && pready_r && pwrite && hit;

   // Register read mux; unused bits read zero, except bits 7:6 of IDX_BASE_WORD_A_HI, which read 01
   always_comb begin
      case (idx)
         `IDX_LEN_LIMIT: rd_nxt = len_limit_r;
         `IDX_FILT_CTRL: rd_nxt = {6'h00, filt_ctrl_r};
         `IDX_CTRL_B:    rd_nxt = ctrl_b_r;
         `IDX_DEV_ADDR:  rd_nxt = dev_addr_r;
         `IDX_CHANNEL_INDEX:      rd_nxt = channel_index_r;
         `IDX_IF_CTRL:   rd_nxt = if_ctrl_r;
         `IDX_OFS_CTRL:  rd_nxt = ofs_r;
         `IDX_BASE_WORD_A_HI:   rd_nxt = {`BASE_WORD_A_TOP, base_word_a_hi_r};
         `IDX_BASE_WORD_A_MID:  rd_nxt = base_word_a_mid_r;
         `IDX_BASE_WORD_A_LO:   rd_nxt = base_word_a_lo_r;
         `IDX_SPACING:   rd_nxt = spacing_r;
         default:        rd_nxt = 8'h00;
      endcase
   end

   // APB answer: ready in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end else begin
         pready_r  <= psel && !penable;
         pslverr_r <= psel && !penable && !hit;
         if (psel && !penable && !pwrite) begin
            prdata_r <= {24'h00_0000, rd_nxt};
         end
      end
   end

   // Packet control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_b_r    <= `RST_CTRL_B;
         dev_addr_r  <= `RST_DEV_ADDR;
         len_limit_r <= `RST_LEN_LIMIT;
         filt_ctrl_r <= `RST_FILT_CTRL;
      end else if (wr_en) begin
         case (idx)
            `IDX_CTRL_B:    ctrl_b_r <= wd & `MASK_CTRL_B;
            `IDX_DEV_ADDR:  dev_addr_r <= wd;
            `IDX_LEN_LIMIT: len_limit_r <= wd;
            `IDX_FILT_CTRL: filt_ctrl_r <= wd[1:0];
            default: ;
         endcase
      end
   end

   // Frequency registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         channel_index_r     <= `RST_CHANNEL_INDEX;
         if_ctrl_r  <= `RST_IF_CTRL;
         ofs_r      <= `RST_OFS_CTRL;
         base_word_a_hi_r  <= `RST_BASE_WORD_A_HI;
         base_word_a_mid_r <= `RST_BASE_WORD_A_MID;
         base_word_a_lo_r  <= `RST_BASE_WORD_A_LO;
         spacing_r  <= `RST_SPACING;
      end else if (wr_en) begin
         case (idx)
            `IDX_CHANNEL_INDEX:     channel_index_r <= wd;
            `IDX_IF_CTRL:  if_ctrl_r <= wd & `MASK_IF_CTRL;
            `IDX_OFS_CTRL: ofs_r <= wd;
            `IDX_BASE_WORD_A_HI:  base_word_a_hi_r <= wd[5:0];
            `IDX_BASE_WORD_A_MID: base_word_a_mid_r <= wd;
            `IDX_BASE_WORD_A_LO:  base_word_a_lo_r <= wd;
            `IDX_SPACING:  spacing_r <= wd;
            default: ;
         endcase
      end
   end

   // Decoded packet engine settings
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pkt_cfg_r <= '0;
      end else begin
         pkt_cfg_r.whiten_on <= ctrl_b_r[`BIT_WHITEN] && !ctrl_b_r[`BIT_LEGACY];
         pkt_cfg_r.legacy_crc <= ctrl_b_r[`BIT_LEGACY];
         pkt_cfg_r.crc_tx_append <= ctrl_b_r[`BIT_CRC];
         pkt_cfg_r.crc_rx_check <= ctrl_b_r[`BIT_CRC];
         pkt_cfg_r.tx_pn9 <= ctrl_b_r[`BIT_FMT_HI:`BIT_FMT_LO] == FMT_PN9;
         pkt_cfg_r.fmt_reserved <= ctrl_b_r[`BIT_FMT_LO];
         pkt_cfg_r.fixed_len <= ctrl_b_r[`BIT_LEN_HI:`BIT_LEN_LO] == LEN_FIXED;
         pkt_cfg_r.var_len <= ctrl_b_r[`BIT_LEN_HI:`BIT_LEN_LO] == LEN_VAR;
         pkt_cfg_r.len_reserved <= ctrl_b_r[`BIT_LEN_HI];
         pkt_cfg_r.len_limit <= len_limit_r;
      end
   end

   // Synthesizer word, all terms in base-word steps
   assign base_w = {`BASE_WORD_A_TOP, base_word_a_hi_r, base_word_a_mid_r, base_word_a_lo_r};
   // Full-width channel term; an 8-bit product would wrap
   assign channel_index_prod = 16'(channel_index_r) * 16'(spacing_r);
   assign tune_w = base_w
                 + {{14{ofs_r[7]}}, ofs_r, 2'b00}
                 + {8'h00, channel_index_prod};
   assign synth_nxt = rx_mode ? tune_w - {13'h0000, if_ctrl_r[4:0], 6'h00} : tune_w;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         synth_r <= '0;
      end else begin
         synth_r.synth_word <= synth_nxt;
         synth_r.mixer_if   <= if_ctrl_r[4:0];
      end
   end

   // PN9 source for random TX, restarts when mode is left
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lfsr_r <= `PN9_SEED;
         pn9_r  <= 1'b0;
      end else if (!pkt_cfg_r.tx_pn9) begin
         lfsr_r <= `PN9_SEED;
         pn9_r  <= 1'b0;
      end else if (tx_bit_strobe) begin
         lfsr_r <= {lfsr_r[7:0], lfsr_r[8] ^ lfsr_r[4]};
         pn9_r  <= lfsr_r[8];
      end
   end

   // Received address filtering
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         accept_r <= 1'b0;
         valid_r  <= 1'b0;
      end else begin
         valid_r <= rx_addr_strobe;
         if (rx_addr_strobe) begin
            accept_r <= addr_match(filt_ctrl_r, dev_addr_r, rx_addr_byte);
         end
      end
   end

   assign prdata      = prdata_r;
   assign pready      = pready_r;
   assign pslverr     = pslverr_r;
   assign pkt_cfg     = pkt_cfg_r;
   assign synth_cfg   = synth_r;
   assign pn9_bit     = pn9_r;
   assign addr_accept = accept_r;
   assign addr_valid  = valid_r;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_whiten_gate: assert property (
      ctrl_b_r[`BIT_LEGACY] |=> !pkt_cfg.whiten_on)
      else $error("whitening on with legacy crc");
   a_legacy_crc: assert property (
      $rose(ctrl_b_r[`BIT_LEGACY]) |=> pkt_cfg.legacy_crc && !pkt_cfg.whiten_on)
      else $error("legacy crc not applied");
   a_crc_enable: assert property (
      !ctrl_b_r[`BIT_CRC] [*2] |-> !pkt_cfg.crc_tx_append && !pkt_cfg.crc_rx_check)
      else $error("crc active while disabled");
   a_pn9_format: assert property (
      ctrl_b_r[`BIT_FMT_HI:`BIT_FMT_LO] == 2'h2 |=> pkt_cfg.tx_pn9 && !pkt_cfg.fmt_reserved)
      else $error("pn9 mode not decoded");
   a_len_modes: assert property (
      $past(presetn) && ctrl_b_r[1:0] == 2'h1
      |=> pkt_cfg.var_len && !pkt_cfg.fixed_len && !pkt_cfg.len_reserved)
      else $error("length mode wrong");
   a_len_limit: assert property (
      $past(presetn) && $stable(len_limit_r) ##1 $stable(len_limit_r)
      |-> pkt_cfg.len_limit == len_limit_r)
      else $error("length limit not passed on");
   a_addr_bcast: assert property (
      rx_addr_strobe && filt_ctrl_r == 2'h3 && rx_addr_byte == 8'hff
      |=> addr_valid && addr_accept)
      else $error("broadcast address refused");
   a_addr_plain: assert property (
      rx_addr_strobe && filt_ctrl_r == 2'h1 && rx_addr_byte != dev_addr_r
      |=> addr_valid && !addr_accept)
      else $error("foreign address accepted");
   a_if_subtract: assert property (
      $rose(rx_mode) && $stable(tune_w) && $stable(if_ctrl_r)
      |=> synth_cfg.synth_word == $past(synth_cfg.synth_word) - {13'h0000, if_ctrl_r[4:0], 6'h00})
      else $error("if not subtracted in rx");
   a_channel_index_step: assert property (
      !rx_mode && $stable(rx_mode) && $changed(channel_index_r) && $stable(spacing_r)
      && $stable(base_w) && $stable(ofs_r)
      |=> synth_cfg.synth_word - $past(synth_cfg.synth_word)
          == 24'($past(channel_index_r) * $past(spacing_r)) - 24'($past(channel_index_r, 2) * $past(spacing_r)))
      else $error("channel step wrong");
   a_base_word_a_top: assert property (
      psel && !penable && !pwrite && idx == `IDX_BASE_WORD_A_HI |=> pready && prdata[7:6] == 2'h1)
      else $error("frequency top bits wrong");
   a_ro_ignore: assert property (
      wr_en && idx == `IDX_CTRL_B |=> !ctrl_b_r[7])
      else $error("unused bit written");
   a_unmapped: assert property (
      psel && !penable && !hit |=> pready && pslverr)
      else $error("unmapped access not refused");
   // Decode, synthesizer, filter and bus checks
   a_whiten_on: assert property (
      $past(presetn) && ctrl_b_r[`BIT_WHITEN] && !ctrl_b_r[`BIT_LEGACY]
      |=> pkt_cfg.whiten_on)
      else $error("whitening not applied");
   a_fixed_len: assert property (
      ctrl_b_r[`BIT_LEN_HI:`BIT_LEN_LO] == 2'h0
      |=> pkt_cfg.fixed_len && !pkt_cfg.var_len && !pkt_cfg.len_reserved)
      else $error("fixed length not decoded");
   a_pn9_idle: assert property (
      !pkt_cfg.tx_pn9
      |=> lfsr_r == `PN9_SEED && !pn9_bit)
      else $error("pn9 source not held at seed");
   a_ofs_add: assert property (
      !rx_mode && $stable(rx_mode) && $changed(ofs_r) && $stable(spacing_r)
      && $stable(base_w) && $stable(channel_index_r)
      |=> synth_cfg.synth_word - $past(synth_cfg.synth_word)
          == (24'($signed($past(ofs_r))) - 24'($signed($past(ofs_r, 2)))) * 24'h000004)
      else $error("offset not added");
   a_mixer_if: assert property (
      $past(presetn) && $stable(if_ctrl_r)
      |-> synth_cfg.mixer_if == if_ctrl_r[4:0])
      else $error("mixer setting not passed on");
   a_channel_index_write: assert property (
      wr_en && idx == `IDX_CHANNEL_INDEX
      |=> channel_index_r == $past(wd))
      else $error("channel write lost");
   a_addr_write: assert property (
      wr_en && idx == `IDX_DEV_ADDR
      |=> dev_addr_r == $past(wd))
      else $error("device address write lost");
   a_if_write: assert property (
      wr_en && idx == `IDX_IF_CTRL
      |=> if_ctrl_r[7:6] == 2'h0 && if_ctrl_r[5:0] == $past(wd[5:0]))
      else $error("if control write wrong");
   a_addr_drop: assert property (
      !rx_addr_strobe
      |=> !addr_valid)
      else $error("address verdict flag stuck");
   a_ready_once: assert property (
      pready
      |=> !pready)
      else $error("ready held too long");

   c_ctrl_write: cover property (wr_en && idx == `IDX_CTRL_B);
   c_pn9_run: cover property (pkt_cfg.tx_pn9 && tx_bit_strobe);
   c_rx_tune: cover property ($rose(rx_mode));
   c_addr_ok: cover property (addr_valid && addr_accept);
   c_fixed_len: cover property (pkt_cfg.fixed_len);

endmodule // radio_packet_base_word_a_config

// File: testbench/radio_far_model.sv
// Far-side packet engine model: address bytes and TX bit pacing
`timescale 1ns/10ps
module radio_far_model (
   input  wire logic pclk,
   output logic      rx_addr_strobe,
   output logic [7:0] rx_addr_byte,
   output logic      tx_bit_strobe
);
   initial begin
      rx_addr_strobe = 1'b0;
      rx_addr_byte = 8'h00;
      tx_bit_strobe = 1'b0;
   end
   // Byte shows inverse once strobe is gone
   task automatic send_addr(input logic [7:0] b);
      @(posedge pclk);
      rx_addr_strobe <= 1'b1;
      rx_addr_byte <= b;
      @(posedge pclk);
      rx_addr_strobe <= 1'b0;
      rx_addr_byte <= ~b;
   endtask
   task automatic tx_bit();
      @(posedge pclk);
      tx_bit_strobe <= 1'b1;
      @(posedge pclk);
      tx_bit_strobe <= 1'b0;
   endtask
endmodule // radio_far_model

// File: testbench/radio_packet_base_word_a_config_test.sv
// Self-checking bench for the packet and synthesizer register block
`timescale 1ns/10ps
`include "radio_cfg_defines.svh"
module radio_packet_base_word_a_config_test
   import radio_cfg_pkg::*;
;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [17:0] paddr = 18'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        rx_mode = 1'b0;
   logic        tx_bit_strobe;
   logic        rx_addr_strobe;
   logic [7:0]  rx_addr_byte;
   pkt_cfg_s    pkt_cfg;
   synth_cfg_s  synth_cfg;
   logic        pn9_bit;
   logic        addr_accept;
   logic        addr_valid;
   int          n_errors = 0;
   int          comparisons = 0;
   logic [31:0] rd;
   logic        err;
   always #20 pclk = ~pclk;
   radio_packet_base_word_a_config #(.AW(18)) i_radio_packet_base_word_a_config (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_mode(rx_mode), .tx_bit_strobe(tx_bit_strobe), .rx_addr_strobe(rx_addr_strobe),
      .rx_addr_byte(rx_addr_byte), .pkt_cfg(pkt_cfg), .synth_cfg(synth_cfg),
      .pn9_bit(pn9_bit), .addr_accept(addr_accept), .addr_valid(addr_valid));
   radio_far_model i_radio_far_model (.pclk(pclk), .rx_addr_strobe(rx_addr_strobe),
      .rx_addr_byte(rx_addr_byte), .tx_bit_strobe(tx_bit_strobe));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge pclk);
      end
      if (n >= 20) n_errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [15:0] idx, input logic [7:0] e);
      apb(1'b0, idx, 8'h00);
      chk(rd, {24'h0, e});
   endtask
   task automatic settle();
      repeat (2) @(posedge pclk);
      #1;
   endtask
   task automatic t_reset();
      chk(pkt_cfg, {1'b1, 1'b0, 2'b11, 3'b000, 2'b10, 8'hff});
      chk(synth_cfg, {24'h5ec4ec, 5'h0f});
      rdchk(`IDX_CTRL_B, 8'h45);
      rdchk(`IDX_DEV_ADDR, 8'h00);
      rdchk(`IDX_CHANNEL_INDEX, 8'h00);
      rdchk(`IDX_IF_CTRL, 8'h0f);
      rdchk(`IDX_OFS_CTRL, 8'h00);
      rdchk(`IDX_BASE_WORD_A_HI, 8'h5e);
      rdchk(`IDX_BASE_WORD_A_MID, 8'hc4);
      rdchk(`IDX_BASE_WORD_A_LO, 8'hec);
      rdchk(`IDX_LEN_LIMIT, 8'hff);
      $display("reset test done");
   endtask
   task automatic t_ro();
      apb(1'b1, `IDX_CTRL_B, 8'hff);
      rdchk(`IDX_CTRL_B, 8'h7f);
      apb(1'b1, `IDX_IF_CTRL, 8'hff);
      rdchk(`IDX_IF_CTRL, 8'h3f);
      apb(1'b1, `IDX_BASE_WORD_A_HI, 8'h80);
      rdchk(`IDX_BASE_WORD_A_HI, 8'h40);
      apb(1'b1, 16'h0100, 8'h55);
      chk({31'h0, err}, 32'h1);
      apb(1'b0, 16'h0100, 8'h00);
      chk(rd, 32'h0);
      $display("read-only test done");
   endtask
   task automatic t_fmt();
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, `IDX_CTRL_B, 8'(c * 16 + c + (c % 2) * 4));
         settle();
         chk(pkt_cfg.tx_pn9, c == 2);
         chk(pkt_cfg.fmt_reserved, c % 2);
         chk(pkt_cfg.fixed_len, c == 0);
         chk(pkt_cfg.var_len, c == 1);
         chk(pkt_cfg.len_reserved, c / 2);
         chk(pkt_cfg.crc_tx_append & pkt_cfg.crc_rx_check, c % 2);
      end
      apb(1'b1, `IDX_CTRL_B, 8'h48);
      settle();
      chk({pkt_cfg.whiten_on, pkt_cfg.legacy_crc}, 2'b01);
      apb(1'b1, `IDX_CTRL_B, 8'h40);
      apb(1'b1, `IDX_LEN_LIMIT, 8'h20);
      settle();
      chk({pkt_cfg.whiten_on, pkt_cfg.legacy_crc, pkt_cfg.len_limit}, 10'h220);
      $display("format test done");
   endtask
   task automatic t_pn9();
      logic [8:0] lf;
      lf = 9'h1ff;
      apb(1'b1, `IDX_CTRL_B, 8'h20);
      settle();
      repeat (24) begin
         i_radio_far_model.tx_bit();
         #1;
         chk(pn9_bit, lf[8]);
         lf = {lf[7:0], lf[8] ^ lf[4]};
      end
      apb(1'b1, `IDX_CTRL_B, 8'h00);
      settle();
      chk(pn9_bit, 1'b0);
      $display("pn9 test done");
   endtask
   task automatic t_synth();
      apb(1'b1, `IDX_BASE_WORD_A_HI, 8'h1e);
      apb(1'b1, `IDX_IF_CTRL, 8'h0f);
      apb(1'b1, `IDX_SPACING, 8'h10);
      apb(1'b1, `IDX_CHANNEL_INDEX, 8'h30);
      apb(1'b1, `IDX_OFS_CTRL, 8'hfe);
      settle();
      chk(synth_cfg.synth_word, 24'h5ec4ec + 24'h300 - 24'h8);
      @(posedge pclk);
      rx_mode <= 1'b1;
      settle();
      chk(synth_cfg, {24'h5ec4ec + 24'h2f8 - 24'h3c0, 5'h0f});
      @(posedge pclk);
      rx_mode <= 1'b0;
      $display("synth test done");
   endtask
   task automatic t_filter();
      logic [15:0] tab;
      logic [7:0] b;
      tab = 16'hf8ce;
      apb(1'b1, `IDX_DEV_ADDR, 8'h5a);
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, `IDX_FILT_CTRL, 8'(m));
         settle();
         for (int k = 0; k < 4; k++) begin
            b = (k == 0) ? 8'h5a : (k == 1) ? 8'h00 : (k == 2) ? 8'hff : 8'h33;
            i_radio_far_model.send_addr(b);
            #1;
            chk({addr_valid, addr_accept}, {1'b1, tab[15 - m * 4 - k]});
         end
      end
      $display("filter test done");
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #(40 * 30000);
      n_errors++;
      final_report();
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      settle();
      t_reset();
      t_ro();
      t_fmt();
      t_pn9();
      t_synth();
      t_filter();
      final_report();
   end
endmodule // radio_packet_base_word_a_config_test
